// ### hw/silence_timer.sv
/*
  One channel's silence timer: counts count+1 steps of a fixed length.
  Assumes start and abort are single-cycle pulses from the channel logic.
*/
`timescale 1ns/1ps
`default_nettype none

module silence_timer
#(
  parameter int STEP_CYCLES = 1000000
)
(
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       start,
  input  wire logic       abort,
  input  wire logic [7:0] count,
  output logic            running,
  output logic            done
);

  localparam logic [19:0] STEP_LAST = 20'(STEP_CYCLES - 1);

  logic [19:0] step_ff;
  logic [7:0]  remain_ff;
  logic        run_ff;
  logic        done_ff;

  // ---------------------------------------------------------------
  // step and count
  // ---------------------------------------------------------------
  // prescaler restarts on start so the first step is a full one
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      step_ff   <= 20'h0_0000;
      remain_ff <= 8'h00;
      run_ff    <= 1'b0;
      done_ff   <= 1'b0;
    end
    else
    begin
      done_ff <= 1'b0;
      if (abort)
      begin
        run_ff <= 1'b0;
      end
      else if (start)
      begin
        step_ff   <= 20'h0_0000;
        remain_ff <= count;
        run_ff    <= 1'b1;
      end
      else if (run_ff)
      begin
        if (step_ff == STEP_LAST)
        begin
          step_ff <= 20'h0_0000;
          if (remain_ff == 8'h00)
          begin
            run_ff  <= 1'b0;
            done_ff <= 1'b1;
          end
          else
          begin
            remain_ff <= remain_ff - 8'h01;
          end
        end
        else
        begin
          step_ff <= step_ff + 20'h0_0001;
        end
      end
    end
  end

  assign running = run_ff;
  assign done    = done_ff;

endmodule

`default_nettype wire

// ### hw/speech_cmd_defines.svh
/*
  Shared constants for the channel stop / silence / repeat command path:
  opcodes, byte fields, timing figures, the channel count and the minimum silence count.
  Assumes a 250 MHz core clock and one command byte per strobe.
*/
// Operation
// - stop byte 0110 halts masked channels
// - stopped channel raises ready and busy
// - stop accepted whatever ready shows
// - host waits busy interval, checks busy
// - host repeats stop if still busy
// - zero channel mask is discarded
// - silence: opcode byte plus count byte
// - silence only to ready channels
// - silence lasts count plus one steps
// - host never sends count below four
// - inserted silence is never looped
// - repeat-set byte 1000 enables looping
// - repeat-set only to ready channels
// - loop until release or stop
// - whole edited phrase replays each loop
// - repeat-release byte 1001 clears looping
// - release accepted whatever ready shows
// - release raises channel ready
`ifndef SPEECH_CMD_DEFINES_SVH
`define SPEECH_CMD_DEFINES_SVH

`define NUM_CH             4
`define OPC_MSB            7
`define OPC_LSB            4
`define MASK_MSB           3
`define MASK_LSB           0
`define OP_STOP            4'h6
`define OP_SILENCE         4'h7
`define OP_REPEAT_SET      4'h8
`define OP_REPEAT_REL      4'h9
`define MASK_NONE          4'h0
`define SILENCE_MIN_COUNT  8'h04

`define CLK_PERIOD_NS      4
`define NS_PER_MS          1000000
`define SILENCE_STEP_MS    4
`define STOP_TIME_NS       40
`define BUSY_LOW_INTERVAL_3_NS 200

`endif

// ### hw/speech_cmd_device.sv
/*
  Device end: decodes stop, silence, repeat-set and repeat-release bytes
  and runs four channel controllers that report ready and busy.
  Assumes the playback datapath outside pulses playStart when a phrase
  (or a whole edited sequence) begins and phraseEnd when it ends, and
  restarts the same sequence on phraseReplay.
*/
`timescale 1ns/1ps
`default_nettype none
`include "speech_cmd_defines.svh"

module speech_cmd_device
  import speech_cmd_pkg::*;
#(
  parameter int SILENCE_STEP_CYCLES = `SILENCE_STEP_MS * `NS_PER_MS / `CLK_PERIOD_NS
)
(
  input  wire logic               clk,
  input  wire logic               arst_n,
  speech_cmd_if.device            bus,
  input  wire logic [`NUM_CH-1:0] playStart,
  input  wire logic [`NUM_CH-1:0] phraseEnd,
  output wire logic [`NUM_CH-1:0] playHalt,
  output wire logic [`NUM_CH-1:0] phraseReplay,
  output wire logic [`NUM_CH-1:0] silenceActive,
  output wire logic [`NUM_CH-1:0] repeatOn
);

  localparam int         STOP_CYCLES = (`STOP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam logic [3:0] STOP_LAST   = 4'(STOP_CYCLES - 1);

  dec_state_t         decState_ff;
  logic [3:0]         argMask_ff;
  logic [3:0]         stopReq_ff;
  logic [3:0]         loopSetReq_ff;
  logic [3:0]         loopRelReq_ff;
  logic [3:0]         silReq_ff;
  logic [7:0]         silCount_ff;
  logic [3:0]         opcode;
  logic [3:0]         mask;

  wire logic [`NUM_CH-1:0] readyVec;
  wire logic [`NUM_CH-1:0] busyNVec;
  wire logic [`NUM_CH-1:0] haltVec;
  wire logic [`NUM_CH-1:0] replayVec;
  wire logic [`NUM_CH-1:0] silVec;
  wire logic [`NUM_CH-1:0] repVec;

  assign opcode = bus.cmdByte[`OPC_MSB:`OPC_LSB];
  assign mask   = bus.cmdByte[`MASK_MSB:`MASK_LSB];

  // ---------------------------------------------------------------
  // byte framing
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      decState_ff <= DEC_OP;
      argMask_ff  <= `MASK_NONE;
    end
    else if (bus.cmdValid)
    begin
      case (decState_ff)
        DEC_OP:
        begin
          // second byte only follows a live mask
          if (opcode == `OP_SILENCE && mask != `MASK_NONE)
          begin
            decState_ff <= DEC_ARG;
            argMask_ff  <= mask;
          end
        end
        default:
        begin
          decState_ff <= DEC_OP;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // command decode to per-channel pulses
  // ---------------------------------------------------------------
  // a zero mask yields all-zero pulses, so the command has no effect
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      stopReq_ff    <= `MASK_NONE;
      loopSetReq_ff <= `MASK_NONE;
      loopRelReq_ff <= `MASK_NONE;
      silReq_ff     <= `MASK_NONE;
      silCount_ff   <= 8'h00;
    end
    else
    begin
      stopReq_ff    <= `MASK_NONE;
      loopSetReq_ff <= `MASK_NONE;
      loopRelReq_ff <= `MASK_NONE;
      silReq_ff     <= `MASK_NONE;
      if (bus.cmdValid && decState_ff == DEC_OP)
      begin
        case (opcode)
          `OP_STOP:       stopReq_ff    <= mask;
          `OP_REPEAT_SET: loopSetReq_ff <= mask & readyVec;
          `OP_REPEAT_REL: loopRelReq_ff <= mask;
          default:        stopReq_ff    <= `MASK_NONE;
        endcase
      end
      else if (bus.cmdValid && decState_ff == DEC_ARG)
      begin
        silReq_ff   <= argMask_ff & readyVec;
        silCount_ff <= bus.cmdByte;
      end
    end
  end

  // ---------------------------------------------------------------
  // channel controllers
  // ---------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `NUM_CH; gi++)
    begin : g_ch
      chan_state_t state_ff;
      chan_state_t nxt_state;
      logic        repeat_ff;
      logic        nxt_repeat;
      logic        silPend_ff;
      logic        nxt_silPend;
      logic [7:0]  pendCount_ff;
      logic [3:0]  stopCnt_ff;
      logic        ready_ff;
      logic        busyN_ff;
      logic        halt_ff;
      logic        replay_ff;
      logic        stopNow;
      logic        endNow;
      logic        tStart;
      logic        tDone;
      logic        tRun;

      assign stopNow = stopReq_ff[gi];
      assign endNow  = phraseEnd[gi] && state_ff == CH_PLAY && !stopNow;
      // silence starts only from idle or after a non-looping phrase
      assign tStart  = !stopNow &&
                       ((state_ff == CH_IDLE && silReq_ff[gi]) ||
                        (endNow && !repeat_ff && silPend_ff));

      silence_timer #(.STEP_CYCLES(SILENCE_STEP_CYCLES)) u_timer
      (
        .clk     (clk),
        .arst_n  (arst_n),
        .start   (tStart),
        .abort   (stopNow),
        .count   (state_ff == CH_IDLE ? silCount_ff : pendCount_ff),
        .running (tRun),
        .done    (tDone)
      );

      always_comb
      begin
        nxt_state   = state_ff;
        nxt_repeat  = repeat_ff;
        nxt_silPend = silPend_ff;
        // loop stays until release or stop
        if (loopSetReq_ff[gi])
          nxt_repeat = 1'b1;
        if (loopRelReq_ff[gi] || stopNow)
          nxt_repeat = 1'b0;
        if (silReq_ff[gi] && state_ff == CH_PLAY)
          nxt_silPend = 1'b1;
        if (tStart || stopNow)
          nxt_silPend = 1'b0;
        case (state_ff)
          CH_IDLE:
          begin
            if (tStart)
              nxt_state = CH_SILENCE;
            else if (playStart[gi] && !stopNow)
              nxt_state = CH_PLAY;
          end
          CH_PLAY:
          begin
            if (stopNow)
              nxt_state = CH_STOP;
            else if (tStart)
              nxt_state = CH_SILENCE;
            else if (endNow && !repeat_ff)
              nxt_state = CH_IDLE;
          end
          CH_SILENCE:
          begin
            if (stopNow)
              nxt_state = CH_STOP;
            else if (tDone)
              nxt_state = CH_IDLE;
          end
          CH_STOP:
          begin
            if (stopCnt_ff == STOP_LAST)
              nxt_state = CH_IDLE;
          end
          default:
          begin
            nxt_state = CH_IDLE;
          end
        endcase
      end

      always_ff @(posedge clk or negedge arst_n)
      begin
        if (!arst_n)
        begin
          state_ff     <= CH_IDLE;
          repeat_ff    <= 1'b0;
          silPend_ff   <= 1'b0;
          pendCount_ff <= 8'h00;
        end
        else
        begin
          state_ff   <= nxt_state;
          repeat_ff  <= nxt_repeat;
          silPend_ff <= nxt_silPend;
          if (silReq_ff[gi] && state_ff == CH_PLAY)
            pendCount_ff <= silCount_ff;
        end
      end

      // stop wind-down time before the channel reports free
      always_ff @(posedge clk or negedge arst_n)
      begin
        if (!arst_n)
          stopCnt_ff <= 4'h0;
        else if (state_ff == CH_STOP)
          stopCnt_ff <= stopCnt_ff + 4'h1;
        else
          stopCnt_ff <= 4'h0;
      end

      always_ff @(posedge clk or negedge arst_n)
      begin
        if (!arst_n)
        begin
          ready_ff  <= 1'b1;
          busyN_ff  <= 1'b1;
          halt_ff   <= 1'b0;
          replay_ff <= 1'b0;
        end
        else
        begin
          // ready once nothing blocks a new command
          ready_ff  <= nxt_state == CH_IDLE ||
                       (nxt_state == CH_PLAY && !nxt_repeat && !nxt_silPend);
          busyN_ff  <= nxt_state == CH_IDLE;
          halt_ff   <= stopNow && state_ff != CH_IDLE;
          replay_ff <= endNow && repeat_ff;
        end
      end

      assign readyVec[gi]  = ready_ff;
      assign busyNVec[gi]  = busyN_ff;
      assign haltVec[gi]   = halt_ff;
      assign replayVec[gi] = replay_ff;
      assign silVec[gi]    = tRun;
      assign repVec[gi]    = repeat_ff;
    end
  endgenerate

  assign bus.channelCmdReady = readyVec;
  assign bus.channelBusyN    = busyNVec;
  assign playHalt            = haltVec;
  assign phraseReplay        = replayVec;
  assign silenceActive       = silVec;
  assign repeatOn            = repVec;

endmodule

`default_nettype wire

// ### hw/speech_cmd_host.sv
/*
  Host end: turns user requests into command bytes, waits on ready
  where a command needs it, and confirms stops by watching busy.
  Assumes the device end on the other side of speech_cmd_if.
*/
`timescale 1ns/1ps
`default_nettype none
`include "speech_cmd_defines.svh"

module speech_cmd_host
  import speech_cmd_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       arst_n,
  speech_cmd_if.host      bus,
  input  wire logic       reqValid,
  input  wire req_op_t    reqOp,
  input  wire logic [3:0] reqMask,
  input  wire logic [7:0] reqCount,
  output logic            reqReady,
  output logic            reqDone,
  output logic            reqRefused
);

  localparam int         WAIT_CYCLES =
    (`BUSY_LOW_INTERVAL_3_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam logic [7:0] WAIT_LAST   = 8'(WAIT_CYCLES - 1);

  host_state_t state_ff;
  host_state_t nxt_state;
  req_op_t     op_ff;
  logic [3:0]  mask_ff;
  logic [7:0]  count_ff;
  logic [7:0]  wait_ff;
  logic        valid_ff;
  logic [7:0]  byte_ff;
  logic [3:0]  opcode;
  logic        needReady;

  always_comb
  begin
    case (op_ff)
      REQ_STOP:       opcode = `OP_STOP;
      REQ_SILENCE:    opcode = `OP_SILENCE;
      REQ_REPEAT_SET: opcode = `OP_REPEAT_SET;
      default:        opcode = `OP_REPEAT_REL;
    endcase
  end

  // these commands wait for ready on every channel in the mask
  assign needReady = op_ff == REQ_SILENCE || op_ff == REQ_REPEAT_SET;

  // ---------------------------------------------------------------
  // sequencing
  // ---------------------------------------------------------------
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      H_IDLE:
      begin
        if (reqValid && reqMask != `MASK_NONE)
          nxt_state = H_WAIT_READY;
      end
      H_WAIT_READY:
      begin
        if (!needReady || (bus.channelCmdReady & mask_ff) == mask_ff)
          nxt_state = H_SEND;
      end
      H_SEND:
      begin
        if (op_ff == REQ_SILENCE)
          nxt_state = H_SEND_ARG;
        else if (op_ff == REQ_STOP)
          nxt_state = H_WAIT_STOP;
        else
          nxt_state = H_IDLE;
      end
      H_SEND_ARG:
      begin
        nxt_state = H_IDLE;
      end
      H_WAIT_STOP:
      begin
        // hold off for the busy interval
        if (wait_ff == WAIT_LAST)
          nxt_state = H_CHECK;
      end
      H_CHECK:
      begin
        // confirm busy high, else stop again
        if ((bus.channelBusyN & mask_ff) == mask_ff)
          nxt_state = H_IDLE;
        else
          nxt_state = H_SEND;
      end
      default:
      begin
        nxt_state = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_ff <= H_IDLE;
      op_ff    <= REQ_STOP;
      mask_ff  <= `MASK_NONE;
      count_ff <= `SILENCE_MIN_COUNT;
    end
    else
    begin
      state_ff <= nxt_state;
      if (state_ff == H_IDLE && reqValid)
      begin
        op_ff   <= reqOp;
        mask_ff <= reqMask;
        // clamp short silences up to the minimum
        count_ff <= (reqCount < `SILENCE_MIN_COUNT) ? `SILENCE_MIN_COUNT : reqCount;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      wait_ff <= 8'h00;
    else if (state_ff == H_WAIT_STOP)
      wait_ff <= wait_ff + 8'h01;
    else
      wait_ff <= 8'h00;
  end

  // ---------------------------------------------------------------
  // outputs, all registered
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      valid_ff   <= 1'b0;
      byte_ff    <= 8'h00;
      reqReady   <= 1'b0;
      reqDone    <= 1'b0;
      reqRefused <= 1'b0;
    end
    else
    begin
      valid_ff   <= nxt_state == H_SEND || nxt_state == H_SEND_ARG;
      byte_ff    <= (nxt_state == H_SEND_ARG) ? count_ff : {opcode, mask_ff};
      reqReady   <= nxt_state == H_IDLE;
      reqDone    <= nxt_state == H_IDLE && state_ff != H_IDLE;
      reqRefused <= state_ff == H_IDLE && reqValid && reqMask == `MASK_NONE;
    end
  end

  assign bus.cmdValid = valid_ff;
  assign bus.cmdByte  = byte_ff;

endmodule

`default_nettype wire

// ### hw/speech_cmd_if.sv
/*
  Command link between host controller and the speech device:
  a byte strobe toward the device, per-channel ready and busy back.
  Assumes both ends share clk; the testbench instantiates and joins them.
*/
`timescale 1ns/1ps
`default_nettype none
`include "speech_cmd_defines.svh"

interface speech_cmd_if;
  logic                 cmdValid;
  logic [7:0]           cmdByte;
  logic [`NUM_CH-1:0]   channelCmdReady;
  logic [`NUM_CH-1:0]   channelBusyN;

  modport device
  (
    input  cmdValid,
    input  cmdByte,
    output channelCmdReady,
    output channelBusyN
  );

  modport host
  (
    output cmdValid,
    output cmdByte,
    input  channelCmdReady,
    input  channelBusyN
  );
endinterface

`default_nettype wire

// ### hw/speech_cmd_pkg.sv
/*
  Types for the command path: channel, decoder and host states,
  and the host-side request kinds.
  Assumes speech_cmd_defines.svh supplies all numeric constants.
*/
package speech_cmd_pkg;

  typedef enum logic [3:0]
  {
    CH_IDLE    = 4'b0001,
    CH_PLAY    = 4'b0010,
    CH_SILENCE = 4'b0100,
    CH_STOP    = 4'b1000
  } chan_state_t;

  typedef enum logic [1:0]
  {
    DEC_OP  = 2'b01,
    DEC_ARG = 2'b10
  } dec_state_t;

  typedef enum logic [5:0]
  {
    H_IDLE       = 6'b00_0001,
    H_WAIT_READY = 6'b00_0010,
    H_SEND       = 6'b00_0100,
    H_SEND_ARG   = 6'b00_1000,
    H_WAIT_STOP  = 6'b01_0000,
    H_CHECK      = 6'b10_0000
  } host_state_t;

  typedef enum logic [1:0]
  {
    REQ_STOP       = 2'h0,
    REQ_SILENCE    = 2'h1,
    REQ_REPEAT_SET = 2'h2,
    REQ_REPEAT_REL = 2'h3
  } req_op_t;

endpackage

// ### test/channel_stop_silence_repeat_cmds_tb.sv
/*
  Bench: host and device ends joined by speech_cmd_if.
  Assumes a shortened silence step; playback pulses come from here.
*/
`timescale 1ns/1ps
`default_nettype none
`include "speech_cmd_defines.svh"

module channel_stop_silence_repeat_cmds_tb
  import speech_cmd_pkg::*;
;
  localparam int STEP  = 10;
  localparam int LIMIT = 20000;
  logic       clk;
  logic       arst_n;
  logic       reqValid;
  logic       reqReady;
  logic       reqDone;
  logic       reqRefused;
  logic       refused;
  req_op_t    reqOp;
  logic [3:0] reqMask;
  logic [7:0] reqCount;
  logic [3:0] playStart;
  logic [3:0] phraseEnd;
  logic [3:0] playHalt;
  logic [3:0] phraseReplay;
  logic [3:0] silenceActive;
  logic [3:0] repeatOn;
  logic [3:0] replaySeen;
  logic [3:0] haltSeen;
  logic [3:0] m;
  logic [7:0] c;
  int         n_errors;
  int         samples_checked;
  int         cyc;
  int         seed;

  speech_cmd_if bus ();
  speech_cmd_host u_speech_cmd_host (.clk(clk), .arst_n(arst_n), .bus(bus), .reqValid(reqValid),
    .reqOp(reqOp), .reqMask(reqMask), .reqCount(reqCount), .reqReady(reqReady),
    .reqDone(reqDone), .reqRefused(reqRefused));
  speech_cmd_device #(.SILENCE_STEP_CYCLES(STEP)) u_speech_cmd_device (.clk(clk),
    .arst_n(arst_n), .bus(bus), .playStart(playStart), .phraseEnd(phraseEnd),
    .playHalt(playHalt), .phraseReplay(phraseReplay), .silenceActive(silenceActive),
    .repeatOn(repeatOn));
  speech_cmd_checker #(.STEP_CYCLES(STEP)) u_speech_cmd_checker (.clk(clk), .arst_n(arst_n),
    .cmdValid(bus.cmdValid), .cmdByte(bus.cmdByte), .channelCmdReady(bus.channelCmdReady),
    .channelBusyN(bus.channelBusyN));

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic end_sim();
    if (n_errors == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // single-cycle pulses are caught here, cleared by the sequence
  always @(posedge clk)
  begin
    replaySeen <= replaySeen | phraseReplay;
    haltSeen   <= haltSeen | playHalt;
    cyc        <= cyc + 1;
    if (cyc == LIMIT)
    begin
      n_errors = n_errors + 1;
      end_sim();
    end
  end

  function automatic int silCycles(input logic [7:0] cnt);
    // short counts are raised to the floor before they are sent
    return (int'((cnt < `SILENCE_MIN_COUNT) ? `SILENCE_MIN_COUNT : cnt) + 1) * STEP;
  endfunction

  task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic ticks(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic pulse(input logic [3:0] s, input logic [3:0] e);
    playStart = s;
    phraseEnd = e;
    @(negedge clk);
    playStart = 4'h0;
    phraseEnd = 4'h0;
    ticks(2);
  endtask

  task automatic req(input req_op_t op, input logic [3:0] msk, input logic [7:0] cnt);
    int k;
    k = 0;
    // a fresh edge first, so reqValid never toggles twice in one step
    do
    begin
      @(negedge clk);
      k++;
    end
    while (reqReady !== 1'b1 && k < 300);
    reqValid = 1'b1;
    reqOp    = op;
    reqMask  = msk;
    reqCount = cnt;
    @(negedge clk);
    reqValid = 1'b0;
    k = 0;
    while (reqDone !== 1'b1 && reqRefused !== 1'b1 && k < 300)
    begin
      @(negedge clk);
      k++;
    end
    refused = reqRefused;
    chk(4'(k < 300), 4'h1);
  endtask

  initial
  begin
    seed = 32'h373b;
    {n_errors, samples_checked, cyc} = '0;
    {reqValid, reqMask, reqCount, playStart, phraseEnd, replaySeen, haltSeen} = '0;
    reqOp  = REQ_STOP;
    arst_n = 1'b0;
    ticks(10);
    arst_n = 1'b1;
    ticks(2);
    chk(bus.channelCmdReady, 4'hF);
    chk(bus.channelBusyN, 4'hF);
    for (int i = 0; i < 4; i++)
    begin
      req(req_op_t'(i), 4'h0, 8'h04);
      chk({3'b000, refused}, 4'h1);
      chk(bus.channelBusyN & bus.channelCmdReady, 4'hF);
    end
    for (int r = 0; r < 12; r++)
    begin
      m = (r == 0) ? 4'hF : 4'($random(seed));
      if (m == 4'h0)
        m = 4'h1;
      // round 1 asks for a count below the floor
      c = (r == 0) ? `SILENCE_MIN_COUNT : (r == 1) ? 8'h01 : 8'({$random(seed)} % 16);
      pulse(m, 4'h0);
      chk(bus.channelBusyN & m, 4'h0);
      req(REQ_REPEAT_SET, m, 8'h00);
      ticks(2);
      chk(repeatOn & m, m);
      chk(bus.channelCmdReady & m, 4'h0);
      replaySeen = 4'h0;
      pulse(4'h0, m);
      chk(replaySeen, m);
      chk(bus.channelBusyN & m, 4'h0);
      req(REQ_REPEAT_REL, m, 8'h00);
      ticks(2);
      chk(repeatOn & m, 4'h0);
      chk(bus.channelCmdReady & m, m);
      req(REQ_REPEAT_SET, m, 8'h00);
      haltSeen = 4'h0;
      // round 2 restarts play after the stop, so the host must stop again
      fork
        req(REQ_STOP, m, 8'h00);
        if (r == 2)
        begin
          ticks(25);
          pulse(m, 4'h0);
        end
      join
      ticks(2);
      chk(haltSeen, m);
      chk(bus.channelCmdReady & bus.channelBusyN & m, m);
      chk(repeatOn & m, 4'h0);
      // odd rounds queue the silence behind a phrase
      if (r[0])
        pulse(m, 4'h0);
      req(REQ_SILENCE, m, c);
      if (r[0])
      begin
        ticks(3);
        chk(bus.channelCmdReady & m, 4'h0);
        replaySeen = 4'h0;
        pulse(4'h0, m);
      end
      ticks(silCycles(c) - 6);
      chk(silenceActive & m, m);
      chk(bus.channelBusyN & m, 4'h0);
      ticks(8);
      chk(bus.channelBusyN & bus.channelCmdReady & m, m);
      chk(replaySeen & {4{r[0]}}, 4'h0);
    end
    end_sim();
  end
endmodule

`default_nettype wire

// ### test/speech_cmd_checker.sv
/*
  Checker for the command link between host and device ends.
  Assumes the bench places it beside the joining interface.
*/
`timescale 1ns/1ps
`default_nettype none
`include "speech_cmd_defines.svh"

module speech_cmd_checker
#(
  parameter int STEP_CYCLES = 10
)
(
  input  wire logic               clk,
  input  wire logic               arst_n,
  input  wire logic               cmdValid,
  input  wire logic [7:0]         cmdByte,
  input  wire logic [`NUM_CH-1:0] channelCmdReady,
  input  wire logic [`NUM_CH-1:0] channelBusyN
);
  localparam int GAP = `BUSY_LOW_INTERVAL_3_NS / `CLK_PERIOD_NS;
  logic        argNext_ff;
  logic        isOp;
  logic [3:0]  opc;
  logic [3:0]  msk;
  logic [3:0]  lastMask_ff;
  logic [3:0]  lastReady_ff;
  logic [3:0]  silMask_ff;
  logic [3:0]  durMask_ff;
  logic [11:0] durCnt_ff;
  logic [5:0]  gap_ff;

  assign opc  = cmdByte[`OPC_MSB:`OPC_LSB];
  assign msk  = cmdByte[`MASK_MSB:`MASK_LSB];
  // a count byte never counts as an opcode
  assign isOp = cmdValid && !argNext_ff;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      argNext_ff   <= 1'b0;
      lastMask_ff  <= 4'h0;
      lastReady_ff <= 4'h0;
      silMask_ff   <= 4'h0;
    end
    else if (cmdValid)
    begin
      argNext_ff <= isOp && opc == `OP_SILENCE && msk != `MASK_NONE;
      if (isOp)
      begin
        lastMask_ff  <= msk;
        lastReady_ff <= channelCmdReady;
      end
      if (isOp && opc == `OP_SILENCE)
        silMask_ff <= msk & channelCmdReady;
    end
  end

  // only idle channels are timed; a stop voids the run
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      durMask_ff <= 4'h0;
      durCnt_ff  <= 12'h000;
      gap_ff     <= 6'h00;
    end
    else
    begin
      if (argNext_ff && cmdValid)
      begin
        durMask_ff <= silMask_ff & channelBusyN;
        durCnt_ff  <= 12'((int'(cmdByte) + 1) * STEP_CYCLES);
      end
      else if (isOp && opc == `OP_STOP)
        durMask_ff <= 4'h0;
      else if (durCnt_ff != 12'h000)
        durCnt_ff <= durCnt_ff - 12'h001;
      if (isOp && opc == `OP_STOP)
        gap_ff <= 6'(GAP);
      else if (gap_ff != 6'h00)
        gap_ff <= gap_ff - 6'h01;
    end
  end

  default clocking dcb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  AST_ZERO_MASK: assert property (isOp && opc inside {[4'h6:4'h9]} |-> msk != 4'h0)
    else $error("empty channel mask sent");
  AST_STOP_DONE: assert property (isOp && opc == `OP_STOP |-> ##12
    ((channelCmdReady & lastMask_ff) == lastMask_ff && (channelBusyN & lastMask_ff) == lastMask_ff))
    else $error("stopped channel not ready and free");
  AST_STOP_QUIET: assert property (gap_ff != 6'h00 |-> !cmdValid)
    else $error("byte sent inside stop wait");
  AST_HOST_READY: assert property (isOp && opc inside {4'h7, 4'h8} |->
    (channelCmdReady & msk) == msk)
    else $error("command sent to busy channel");
  // an idle channel may hold a loop for its next phrase and stay ready
  AST_SET_READY: assert property (isOp && opc == `OP_REPEAT_SET |-> ##2
    (channelCmdReady & ~channelBusyN & lastMask_ff & lastReady_ff) == 4'h0)
    else $error("ready high while looping");
  AST_REL_READY: assert property (isOp && opc == `OP_REPEAT_REL |-> ##2
    (channelCmdReady & lastMask_ff) == lastMask_ff)
    else $error("ready low after loop release");
  AST_SIL_START: assert property (argNext_ff && cmdValid |-> ##2
    ((channelBusyN & silMask_ff) == 4'h0 && (channelCmdReady & silMask_ff) == 4'h0))
    else $error("silence did not take channel");
  AST_SIL_LENGTH: assert property (durCnt_ff == 12'h001 && durMask_ff != 4'h0 |->
    (channelBusyN & durMask_ff) == 4'h0 ##[1:4] (channelBusyN & durMask_ff) == durMask_ff)
    else $error("silence length wrong");
  AST_SIL_COUNT: assert property (argNext_ff && cmdValid |-> cmdByte >= `SILENCE_MIN_COUNT)
    else $error("silence count below floor");

  cover property (isOp && opc == `OP_STOP);
  cover property (argNext_ff && cmdValid && (silMask_ff & channelBusyN) != 4'h0);
  cover property (isOp && opc == `OP_REPEAT_REL && (channelCmdReady & msk) != msk);
endmodule

`default_nettype wire
